// >>> rtl/dbm_consts.svh
// field positions, reset values and counts of the base mode word
`ifndef DBM_CONSTS_SVH
`define DBM_CONSTS_SVH
`define DBM_MODE_W 19
`define DBM_MODE_RST 19'h00000
`define DBM_RSVD_MASK 19'h4e080
`define DBM_BL_LSB 0
`define DBM_BT_BIT 3
`define DBM_CL_LO_BIT 2
`define DBM_CL_LSB 4
`define DBM_DLL_RST_BIT 8
`define DBM_WR_LSB 9
`define DBM_PD_BIT 12
`define DBM_BL_FIXED8 2'h0
`define DBM_BL_OTF 2'h1
`define DBM_BL_CHOP4 2'h2
`define DBM_DLL_LOCK_CYCLES 512
`define DBM_FIFO_DEPTH 8
`endif

// >>> rtl/dbm_fifo.sv
// write beat fifo with registered storage
`timescale 1ns/1ps
`default_nettype none
module dbm_fifo
  import dbm_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 8
)(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // stream
  dbm_fifo_if.fifo f
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  assign f.in_ready = (count != CW'(DEPTH));
  assign f.out_valid = (count != '0);
  assign f.out_data = mem[rd_ptr];
  assign push = f.in_valid && f.in_ready;
  assign pop = f.out_valid && f.out_ready;

  always_comb
  begin
    next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop)
      next_count = CW'(count + 1'b1);
    else if (pop && !push)
      next_count = CW'(count - 1'b1);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr] <= f.in_data;
  end
endmodule
`default_nettype wire

// >>> rtl/dbm_fifo_if.sv
// stream carrier between the core and its write fifo
`timescale 1ns/1ps
`default_nettype none
interface dbm_fifo_if #(parameter int W = 8);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// >>> rtl/dbm_mode_core.sv
// base mode word decode, burst ordering, read latency and dll reset
`timescale 1ns/1ps
`default_nettype none
`include "dbm_consts.svh"
module dbm_mode_core
  import dbm_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int COL_W = 10,
  parameter int FIFO_DEPTH = `DBM_FIFO_DEPTH,
  parameter int DLL_LOCK_CYCLES = `DBM_DLL_LOCK_CYCLES
)(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // command and address
  input wire logic cmd_valid,
  input wire dbm_cmd_t cmd_kind,
  output logic cmd_ready,
  input wire logic [`DBM_MODE_W-1:0] mode_in,
  input wire logic [COL_W-1:0] col_addr,
  input wire logic burst_select_line,
  // power-down state
  input wire logic pd_active,
  // data and strobe pins
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic wr_beat_valid,
  output logic wr_beat_ready,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic strobe_oe,
  // array side
  output logic [COL_W-1:0] rd_col,
  output logic rd_col_valid,
  input wire logic [DATA_W-1:0] rd_data,
  output logic [COL_W+DATA_W-1:0] array_wr_word,
  output logic array_wr_valid,
  input wire logic array_wr_ready,
  // decoded settings
  output logic [3:0] read_latency,
  output logic [3:0] write_recovery,
  output logic interleaved,
  output logic dll_running,
  output logic dll_locked,
  output logic dll_reset_pending
);
  localparam int DW = $clog2(DLL_LOCK_CYCLES + 1);
  localparam int FW = COL_W + DATA_W;

  dbm_state_t state, next_state;
  logic [`DBM_MODE_W-1:0] mode, next_mode;
  logic [3:0] lat_cnt, next_lat_cnt;
  logic [2:0] beat, next_beat;
  logic cur_chop, next_cur_chop;
  logic [COL_W-1:0] start_col, next_start_col;
  logic [DW-1:0] dll_cnt, next_dll_cnt;
  logic [DATA_W-1:0] next_dq_out;
  logic next_dq_oe;
  logic cmd_take, wr_take, drop_slot;
  logic [2:0] cur_col;

  dbm_fifo_if #(.W(FW)) wq ();

  dbm_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .f(wq)
  );

  // chop decision for a command
  function automatic logic chop_of(input logic [1:0] bl, input logic sel);
    logic c;
    c = 1'b0;
    if (bl == `DBM_BL_CHOP4)
      c = 1'b1;
    else if (bl == `DBM_BL_OTF)
      c = !sel;
    return c;
  endfunction

  // low column bits of one beat
  function automatic logic [2:0] beat_col(input logic [2:0] s, input logic [2:0] idx,
                                          input logic ilv, input logic chop, input logic wr);
    logic [2:0] c;
    if (wr)
      c = chop ? {s[2], idx[1:0]} : idx;
    else if (ilv)
      c = s ^ idx;
    else
      c = {s[2] ^ idx[2], 2'(s[1:0] + idx[1:0])};
    return c;
  endfunction

  // read latency field decode
  function automatic logic [3:0] cl_decode(input logic [2:0] code, input logic lo);
    logic [4:0] v;
    v = lo ? 5'(5'h0c + code) : 5'(5'h04 + code);
    if (v == 5'h04)
      v = 5'h05;
    if (v > 5'h0e)
      v = 5'h0e;
    return v[3:0];
  endfunction

  // write recovery field decode
  function automatic logic [3:0] wr_decode(input logic [2:0] code);
    logic [3:0] v;
    if (code == 3'h0)
      v = 4'he;
    else if (code <= 3'h4)
      v = {1'b0, code} + 4'h4;
    else
      v = {code, 1'b0};
    return v;
  endfunction

  assign read_latency = cl_decode(mode[`DBM_CL_LSB+2:`DBM_CL_LSB], mode[`DBM_CL_LO_BIT]);
  assign write_recovery = wr_decode(mode[`DBM_WR_LSB+2:`DBM_WR_LSB]);
  assign interleaved = mode[`DBM_BT_BIT];
  // dll stops in power-down when bit clear
  // dll keeps running when bit set
  assign dll_running = !(pd_active && !mode[`DBM_PD_BIT]);
  assign dll_locked = (dll_cnt == '0);
  assign dll_reset_pending = mode[`DBM_DLL_RST_BIT];
  assign strobe_oe = dq_oe;

  assign cmd_ready = (state == st_idle);
  assign cmd_take = cmd_valid && cmd_ready;
  // sequential order, interleaved order, write order
  assign cur_col = beat_col(start_col[2:0], beat, interleaved, cur_chop,
                            state == st_wr_burst);
  // beats wrap inside the aligned block
  assign rd_col = {start_col[COL_W-1:3], cur_col};
  assign rd_col_valid = (state == st_rd_burst) && !(cur_chop && beat[2]);

  // chop slots four to seven are don't care
  assign drop_slot = cur_chop && beat[2];
  assign wr_beat_ready = (state == st_wr_burst) && (wq.in_ready || drop_slot);
  assign wr_take = wr_beat_valid && wr_beat_ready;
  assign wq.in_valid = (state == st_wr_burst) && wr_beat_valid && !drop_slot;
  assign wq.in_data = {start_col[COL_W-1:3], cur_col, dq_in};
  assign array_wr_word = wq.out_data;
  assign array_wr_valid = wq.out_valid;
  assign wq.out_ready = array_wr_ready;

  always_comb
  begin
    next_state = state;
    next_mode = mode;
    next_lat_cnt = lat_cnt;
    next_beat = beat;
    next_cur_chop = cur_chop;
    next_start_col = start_col;
    next_dll_cnt = (dll_cnt != '0) ? DW'(dll_cnt - 1'b1) : dll_cnt;
    next_dq_out = dq_out;
    next_dq_oe = 1'b0;
    // self-clear once the dll reset is under way
    if (mode[`DBM_DLL_RST_BIT])
      next_mode[`DBM_DLL_RST_BIT] = 1'b0;
    case (state)
      st_idle:
      begin
        if (cmd_take && cmd_kind == cmd_mode_set)
        begin
          // reserved bits are stored as zero
          next_mode = mode_in & ~`DBM_RSVD_MASK;
          // start of dll reset and lock wait
          if (mode_in[`DBM_DLL_RST_BIT])
            next_dll_cnt = DW'(DLL_LOCK_CYCLES);
        end
        else if (cmd_take && (cmd_kind == cmd_read || cmd_kind == cmd_write))
        begin
          next_cur_chop = chop_of(mode[`DBM_BL_LSB+1:`DBM_BL_LSB], burst_select_line);
          next_start_col = col_addr;
          next_beat = 3'h0;
          // count to edge n plus latency
          next_lat_cnt = read_latency - 4'h2;
          next_state = (cmd_kind == cmd_read) ? st_rd_wait : st_wr_burst;
        end
      end
      st_rd_wait:
      begin
        if (lat_cnt == 4'h0)
          next_state = st_rd_burst;
        else
          next_lat_cnt = lat_cnt - 4'h1;
      end
      st_rd_burst:
      begin
        next_dq_oe = rd_col_valid;
        next_dq_out = rd_data;
        // chop keeps the full eight slot frame
        next_beat = beat + 3'h1;
        if (beat == 3'h7)
          next_state = st_idle;
      end
      st_wr_burst:
      begin
        if (wr_take)
        begin
          next_beat = beat + 3'h1;
          if (beat == 3'h7)
            next_state = st_idle;
        end
      end
      default:
        next_state = st_idle;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= st_idle;
      mode <= `DBM_MODE_RST;
      lat_cnt <= 4'h0;
      beat <= 3'h0;
      cur_chop <= 1'b0;
      start_col <= '0;
      dll_cnt <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      mode <= next_mode;
      lat_cnt <= next_lat_cnt;
      beat <= next_beat;
      cur_chop <= next_cur_chop;
      start_col <= next_start_col;
      dll_cnt <= next_dll_cnt;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
    end
  end

  // helper: cycles since a read was taken
  logic [4:0] rd_age;
  logic [3:0] rd_lat;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rd_age <= 5'h00;
      rd_lat <= 4'h0;
    end
    else if (cmd_take && cmd_kind == cmd_read)
    begin
      rd_age <= 5'h00;
      rd_lat <= read_latency;
    end
    else if (rd_age != 5'h1f)
      rd_age <= rd_age + 5'h01;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence chop_burst_s;
    dq_oe [*4] ##1 (!dq_oe) [*4];
  endsequence
  sequence full_burst_s;
    dq_oe [*8] ##1 !dq_oe;
  endsequence

  first_beat_time_a: assert property ($rose(dq_oe) |-> rd_age == {1'b0, rd_lat})
    else $error("first read beat not at latency edge");
  chop_float_a: assert property ($rose(dq_oe) && cur_chop |-> chop_burst_s)
    else $error("chopped read beat count wrong");
  full_drive_a: assert property ($rose(dq_oe) && !cur_chop |-> full_burst_s)
    else $error("full read beat count wrong");
  ilv_order_a: assert property (rd_col_valid && interleaved |->
    rd_col[2:0] == (start_col[2:0] ^ beat))
    else $error("interleaved column wrong");
  seq_order_a: assert property (rd_col_valid && !interleaved |->
    rd_col[2:0] == {start_col[2] ^ beat[2], 2'(start_col[1:0] + beat[1:0])} &&
    rd_col[COL_W-1:3] == start_col[COL_W-1:3])
    else $error("sequential column wrong");
  wr_order_a: assert property (wq.in_valid |->
    wq.in_data[DATA_W+2:DATA_W] == (cur_chop ? {start_col[2], beat[1:0]} : beat))
    else $error("write column order wrong");
  otf_select_a: assert property (cmd_take && cmd_kind inside {cmd_read, cmd_write} &&
    mode[1:0] == `DBM_BL_OTF |=> cur_chop == !$past(burst_select_line))
    else $error("per-command burst select wrong");
  fixed_code_a: assert property (cmd_take && cmd_kind inside {cmd_read, cmd_write} &&
    mode[1:0] != `DBM_BL_OTF |=> cur_chop == ($past(mode[1:0]) == `DBM_BL_CHOP4))
    else $error("fixed burst code wrong");
  dll_clear_a: assert property (cmd_take && cmd_kind == cmd_mode_set &&
    mode_in[`DBM_DLL_RST_BIT] |=> dll_reset_pending ##1 !dll_reset_pending)
    else $error("dll reset bit did not self clear");
  dll_wait_a: assert property ($fell(dll_locked) |-> dll_cnt == DW'(DLL_LOCK_CYCLES))
    else $error("dll lock wait length wrong");
  pd_dll_a: assert property (pd_active && !mode[`DBM_PD_BIT] |-> !dll_running)
    else $error("dll running in slow power-down");
  lat_range_a: assert property (read_latency inside {[4'h5:4'he]} &&
    write_recovery inside {4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'he})
    else $error("decoded timing out of range");
endmodule
`default_nettype wire

// >>> rtl/dbm_pkg.sv
// types shared by the base mode block
package dbm_pkg;
  typedef enum logic [1:0] {cmd_nop, cmd_mode_set, cmd_read, cmd_write} dbm_cmd_t;
  typedef enum logic [1:0] {st_idle, st_rd_wait, st_rd_burst, st_wr_burst} dbm_state_t;
endpackage

// >>> verif/dbm_array_model.sv
// array model answering column reads and taking write words
`timescale 1ns/1ps
`default_nettype none
module dbm_array_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // read side
  input wire logic [9:0] rd_col,
  input wire logic rd_col_valid,
  output logic [7:0] rd_data,
  // write side
  output logic array_wr_ready,
  input wire logic stall
);
  logic tog;
  always_ff @(posedge core_clk)
  begin
    tog <= rst_n ? ~tog : 1'b0;
  end
  // data toggles every cycle while no column is asked for
  assign rd_data = rd_col_valid ? (rd_col[7:0] ^ 8'h5a) : {8{tog}};
  assign array_wr_ready = ~stall;
endmodule
`default_nettype wire

// >>> verif/dbm_mode_core_tb_top.sv
// self-checking bench for the base mode core
`timescale 1ns/1ps
`default_nettype none
module dbm_mode_core_tb_top;
  import dbm_pkg::*;
  localparam int LOCK = 8;
  logic core_clk, rst_n, cmd_valid, cmd_ready, burst_select_line, pd_active, stall;
  dbm_cmd_t cmd_kind;
  logic [18:0] mode_in, m;
  logic [9:0] col_addr, rd_col;
  logic [7:0] dq_in, dq_out, rd_data;
  logic wr_beat_valid, wr_beat_ready, dq_oe, strobe_oe, rd_col_valid, saw_full;
  logic [17:0] array_wr_word;
  logic array_wr_valid, array_wr_ready, interleaved, dll_running, dll_locked, dll_reset_pending;
  logic [3:0] read_latency, write_recovery;
  logic [2:0] s, e;
  logic ch, ilv, bs, oe;
  logic [1:0] bc;
  int mismatches, checks_done, k, c, el, ew;
  logic [17:0] wq[$], eq[$];
  dbm_mode_core #(.DLL_LOCK_CYCLES(LOCK)) DUT (.core_clk(core_clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_ready(cmd_ready), .mode_in(mode_in),
    .col_addr(col_addr), .burst_select_line(burst_select_line), .pd_active(pd_active),
    .dq_in(dq_in), .wr_beat_valid(wr_beat_valid), .wr_beat_ready(wr_beat_ready),
    .dq_out(dq_out), .dq_oe(dq_oe), .strobe_oe(strobe_oe), .rd_col(rd_col),
    .rd_col_valid(rd_col_valid), .rd_data(rd_data), .array_wr_word(array_wr_word),
    .array_wr_valid(array_wr_valid), .array_wr_ready(array_wr_ready),
    .read_latency(read_latency), .write_recovery(write_recovery), .interleaved(interleaved),
    .dll_running(dll_running), .dll_locked(dll_locked), .dll_reset_pending(dll_reset_pending));
  dbm_array_model u_array (.core_clk(core_clk), .rst_n(rst_n), .rd_col(rd_col),
    .rd_col_valid(rd_col_valid), .rd_data(rd_data), .array_wr_ready(array_wr_ready),
    .stall(stall));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // collect words handed to the array, note refused beats
  always @(posedge core_clk)
  begin
    if (array_wr_valid === 1'b1 && array_wr_ready === 1'b1)
      wq.push_back(array_wr_word);
    if (wr_beat_valid === 1'b1 && wr_beat_ready === 1'b0)
      saw_full = 1'b1;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  // one command, held until the core takes it
  task automatic cmd(input dbm_cmd_t kd, input logic [18:0] mw, input logic [9:0] ca,
    input logic b);
    tick();
    cmd_valid = 1'b1;
    cmd_kind = kd;
    mode_in = mw;
    col_addr = ca;
    burst_select_line = b;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 50)
    begin
      tick();
      k++;
    end
    if (k >= 50)
      mismatches++;
    tick();
    cmd_valid = 1'b0;
  endtask
  // write of eight beats, expected array words queued
  task automatic wr(input logic chp, input logic b, input logic [2:0] st, input logic [7:0] d);
    cmd(cmd_write, 19'h0, {7'h2a, st}, b);
    for (int i = 0; i < 8; i++)
    begin
      wr_beat_valid = 1'b1;
      dq_in = d + 8'(i);
      k = 0;
      while (wr_beat_ready !== 1'b1 && k < 60)
      begin
        tick();
        k++;
      end
      if (k >= 60)
        mismatches++;
      tick();
      if (!chp || i < 4)
        eq.push_back({7'h2a, chp ? {st[2], 2'(i)} : 3'(i), d + 8'(i)});
    end
    wr_beat_valid = 1'b0;
  endtask
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    saw_full = 1'b0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = cmd_nop;
    mode_in = 19'h0;
    col_addr = 10'h0;
    burst_select_line = 1'b0;
    pd_active = 1'b0;
    dq_in = 8'h0;
    wr_beat_valid = 1'b0;
    stall = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    chk({cmd_ready, dq_oe, dll_locked, read_latency, write_recovery,
      interleaved, dll_running}, {5'h0, 13'b1_0_1_0101_1110_0_1});
    $display("test reset done");
    pd_active = 1'b1;
    for (int j = 0; j < 16; j++)
    begin
      c = j % 8;
      el = j[3] ? ((c > 2) ? 14 : 12 + c) : ((c == 0) ? 5 : 4 + c);
      ew = (c == 0) ? 14 : ((c < 5) ? c + 4 : 2 * c);
      m = (19'(c) << 9) | (19'(c) << 4) | (19'(j[3]) << 2) | (19'(c[1]) << 3) | (19'(c[0]) << 12);
      cmd(cmd_mode_set, m, 10'h0, 1'b0);
      chk({read_latency, write_recovery, interleaved, dll_running},
        {4'(el), 4'(ew), c[1], c[0]});
    end
    pd_active = 1'b0;
    $display("test decode done");
    cmd(cmd_mode_set, 19'h100, 10'h0, 1'b0);
    chk({dll_reset_pending, dll_locked}, 18'h2);
    tick();
    chk(dll_reset_pending, 18'h0);
    k = 1;
    while (dll_locked !== 1'b1 && k < 40)
    begin
      tick();
      k++;
    end
    chk(18'(k), 18'(LOCK));
    $display("test dll done");
    // reads only after the lock wait
    for (int j = 0; j < 64; j++)
    begin
      bc = (j[5:4] == 2'd3) ? 2'd1 : j[5:4];
      bs = (j[5:4] == 2'd3);
      ch = (j[5:4] == 2'd1) || (j[5:4] == 2'd2);
      ilv = j[3];
      s = j[2:0];
      cmd(cmd_mode_set, 19'h20 | (19'(ilv) << 3) | 19'(bc), 10'h0, 1'b0);
      cmd(cmd_read, 19'h0, {7'h55, s}, bs);
      k = 0;
      while (dq_oe !== 1'b1 && k < 30)
      begin
        tick();
        k++;
      end
      chk(18'(k), 18'd6);
      for (int i = 0; i < 8; i++)
      begin
        e = ilv ? s ^ 3'(i) : {s[2] ^ i[2], s[1:0] + 2'(i)};
        oe = !(ch && i > 3);
        chk({dq_oe, strobe_oe, dq_oe ? dq_out : 8'h0},
          {oe, oe, oe ? {5'h15, e} ^ 8'h5a : 8'h0});
        tick();
      end
      chk(dq_oe, 18'h0);
    end
    $display("test reads done");
    cmd(cmd_mode_set, 19'h9, 10'h0, 1'b0);
    wr(1'b1, 1'b0, 3'h5, 8'h40);
    wr(1'b0, 1'b1, 3'h6, 8'h80);
    cmd(cmd_mode_set, 19'h2, 10'h0, 1'b0);
    wr(1'b1, 1'b1, 3'h7, 8'ha0);
    cmd(cmd_mode_set, 19'h3, 10'h0, 1'b0);
    stall = 1'b1;
    fork
      begin
        repeat (40) @(posedge core_clk);
        #1;
        stall = 1'b0;
      end
    join_none
    wr(1'b0, 1'b0, 3'h3, 8'hc0);
    wr(1'b0, 1'b0, 3'h1, 8'he0);
    k = 0;
    while (wq.size() < eq.size() && k < 200)
    begin
      tick();
      k++;
    end
    chk({saw_full, 17'(wq.size())}, {1'b1, 17'(eq.size())});
    for (int i = 0; i < eq.size() && i < wq.size(); i++)
      chk(wq[i], eq[i]);
    $display("test writes done");
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
